// >>> inc/dsm_pkg.sv
// constants, register map and carrier types of the drive status monitor mux
package dsm_pkg;

   localparam int ITEM_W = 4;
   localparam int DATA_W = 32;
   localparam int CFG_W = 16;
   localparam int WORD_W = 20;
   localparam int ADDR_W = 4;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_ITEM = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CFG = 4'h1;
   localparam logic [ADDR_W-1:0] REG_VALUE = 4'h2;

   // reset values
   localparam logic [ITEM_W-1:0] ITEM_RST = 4'h0;
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

   // configuration bit positions and position error scale divisor
   localparam int CFG_REV_BIT = 0;
   localparam int CFG_PULSE_INV_BIT = 13;
   localparam int CFG_ERR_SCALE_BIT = 14;
   localparam logic signed [DATA_W-1:0] ERR_SCALE_DIV = 32'sh00000064;

   // monitor item numbers
   localparam logic [ITEM_W-1:0] ITEM_ACT_SPEED = 4'h0;
   localparam logic [ITEM_W-1:0] ITEM_TGT_SPEED = 4'h1;
   localparam logic [ITEM_W-1:0] ITEM_TORQUE = 4'h2;
   localparam logic [ITEM_W-1:0] ITEM_U_PULSES = 4'h3;
   localparam logic [ITEM_W-1:0] ITEM_ELEC_ANGLE = 4'h4;
   localparam logic [ITEM_W-1:0] ITEM_WORD_ONE = 4'h5;
   localparam logic [ITEM_W-1:0] ITEM_WORD_TWO = 4'h6;
   localparam logic [ITEM_W-1:0] ITEM_CMD_SPEED = 4'h7;
   localparam logic [ITEM_W-1:0] ITEM_POS_ERR = 4'h8;
   localparam logic [ITEM_W-1:0] ITEM_CMD_COUNT = 4'h9;
   localparam logic [ITEM_W-1:0] ITEM_WORD_THREE = 4'ha;
   localparam logic [ITEM_W-1:0] ITEM_WORD_FOUR = 4'hb;
   localparam logic [ITEM_W-1:0] ITEM_WORD_FIVE = 4'hc;
   localparam logic [ITEM_W-1:0] ITEM_SW_POS = 4'hd;
   localparam logic [ITEM_W-1:0] ITEM_SW_SPD = 4'he;
   localparam logic [ITEM_W-1:0] ITEM_CUR_POS = 4'hf;

   // connector and encoder pin levels, asynchronous to core_clk
   typedef struct packed {
      logic enc_a;
      logic enc_b;
      logic enc_c;
      logic enc_u;
      logic enc_v;
      logic enc_w;
      logic line_pg_c;
      logic cmd_pulse_a;
      logic cmd_pulse_b;
      logic servo_on_in_n;
      logic prop_ctrl_in_n;
      logic fwd_overtravel_in;
      logic rev_overtravel_in;
      logic homing_in_n;
      logic manual_in_n;
      logic pulse_in_n;
      logic jog_fwd_in_n;
      logic jog_rev_in_n;
      logic reset_in_n;
      logic second_speed_in_n;
      logic third_speed_in_n;
      logic latch_in_n;
      logic auto_start_in_n;
      logic alarm_clear_in_n;
      logic stop_in_n;
      logic [11:0] code_data_in_n;
      logic [1:0] dir_select_in_n;
      logic [1:0] pos_select_in_n;
   } dsm_pins_t;

   // internal flags from the control core, same clock
   typedef struct packed {
      logic servo_alarm;
      logic dyn_brake;
      logic rotating;
      logic pos_done;
      logic p_ctrl;
      logic fwd_ilim;
      logic rev_ilim;
      logic motor_power;
      logic ilim;
      logic brake_release;
      logic overload_warn;
      logic main_power;
      logic servo_ready;
      logic enc_incremental;
   } dsm_flags_t;

   // output contact levels driven by the drive, same clock
   typedef struct packed {
      logic auto_latch_out_n;
      logic manual_latch_out_n;
      logic [1:0] position_out_n;
      logic [3:0] alarm_code_out_n;
      logic error_out_n;
      logic [4:0] point_out_n;
   } dsm_outs_t;

   // numeric quantities from the control core, same clock
   typedef struct packed {
      logic signed [DATA_W-1:0] act_speed;
      logic signed [DATA_W-1:0] tgt_speed;
      logic signed [15:0] torque_pct;
      logic [15:0] elec_angle;
      logic signed [DATA_W-1:0] cmd_speed;
      logic signed [DATA_W-1:0] pos_error;
      logic signed [DATA_W-1:0] sw_pos;
      logic signed [DATA_W-1:0] sw_spd;
      logic signed [DATA_W-1:0] cur_pos;
      logic cmd_step_up;
      logic cmd_step_down;
   } dsm_numeric_t;

   // register port from host or panel
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } dsm_bus_req_t;

   // displayed item towards the panel
   typedef struct packed {
      logic [ITEM_W-1:0] item;
      logic [DATA_W-1:0] value;
   } dsm_display_t;

   typedef struct packed {
      logic [ITEM_W-1:0] item;
      logic [CFG_W-1:0] cfg;
      logic [DATA_W-1:0] rdata;
      dsm_display_t disp;
      logic [WORD_W-1:0] word_one;
      logic [WORD_W-1:0] word_two;
      logic [WORD_W-1:0] word_three;
      logic [WORD_W-1:0] word_four;
      logic [WORD_W-1:0] word_five;
      logic signed [DATA_W-1:0] u_pulses;
      logic [15:0] cmd_count;
      logic [1:0] prev_ab;
      logic prev_u;
   } dsm_state_t;

endpackage

// >>> hdl/dsm_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module dsm_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dsm_sync_state_t;

   dsm_sync_state_t st;
   dsm_sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.meta = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;
endmodule

// >>> hdl/dsm_monitor.sv
// drive status monitor: item select, numeric items and bit display words
`timescale 1ns/10ps
module dsm_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire dsm_pkg::dsm_bus_req_t bus_req,
   output logic [dsm_pkg::DATA_W-1:0] bus_rdata,
   input wire dsm_pkg::dsm_pins_t pin_in,
   input wire dsm_pkg::dsm_flags_t core_flags,
   input wire dsm_pkg::dsm_outs_t core_outs,
   input wire dsm_pkg::dsm_numeric_t core_num,
   output dsm_pkg::dsm_display_t display
);
   import dsm_pkg::*;

   dsm_state_t st;
   dsm_state_t next_st;
   dsm_pins_t pins;

   // address decode shared by write and read paths
   function automatic logic reg_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] offset
   );
      reg_hit = (addr == offset);
   endfunction

   // pins pass two flops before any logic looks at them
   dsm_sync #(
      .W($bits(dsm_pins_t))
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pin_in),
      .sync_out(pins)
   );

   always_comb begin
      logic [1:0] cur_ab;
      logic ab_step;
      logic ab_fwd;
      logic u_edge;
      logic signed [DATA_W-1:0] err_scaled;
      logic [DATA_W-1:0] value;
      cur_ab = '0;
      ab_step = 1'h0;
      ab_fwd = 1'h0;
      u_edge = 1'h0;
      err_scaled = '0;
      value = '0;
      next_st = st;

      // register writes
      if (bus_req.wr) begin
         if (reg_hit(bus_req.addr, REG_ITEM)) begin
            next_st.item = bus_req.wdata[ITEM_W-1:0];
         end
         if (reg_hit(bus_req.addr, REG_CFG)) begin
            next_st.cfg = bus_req.wdata[CFG_W-1:0];
         end
      end

      // status word one
      next_st.word_one = {
         1'h0,
         pins.rev_overtravel_in,
         pins.fwd_overtravel_in,
         ~pins.prop_ctrl_in_n,
         ~pins.servo_on_in_n,
         ~pins.enc_w & core_flags.enc_incremental,
         ~pins.enc_v & core_flags.enc_incremental,
         ~pins.enc_u & core_flags.enc_incremental,
         ~pins.enc_c,
         ~pins.enc_b,
         ~pins.enc_a,
         core_flags.motor_power,
         core_flags.rev_ilim,
         core_flags.fwd_ilim,
         core_flags.p_ctrl,
         core_flags.pos_done,
         core_flags.rotating,
         st.cfg[CFG_REV_BIT],
         core_flags.dyn_brake,
         core_flags.servo_alarm
      };

      // status word two
      next_st.word_two = {
         12'h000,
         core_flags.servo_ready,
         core_flags.main_power,
         core_flags.overload_warn,
         core_flags.brake_release,
         core_flags.ilim,
         ~pins.line_pg_c,
         pins.cmd_pulse_b ^ st.cfg[CFG_PULSE_INV_BIT],
         pins.cmd_pulse_a ^ st.cfg[CFG_PULSE_INV_BIT]
      };

      // status word three
      next_st.word_three = {
         8'h00,
         ~pins.stop_in_n,
         ~pins.alarm_clear_in_n,
         ~pins.auto_start_in_n,
         ~pins.latch_in_n,
         ~pins.third_speed_in_n,
         ~pins.second_speed_in_n,
         ~pins.reset_in_n,
         ~pins.jog_rev_in_n,
         ~pins.jog_fwd_in_n,
         ~pins.pulse_in_n,
         ~pins.manual_in_n,
         ~pins.homing_in_n
      };

      // status word four
      next_st.word_four = {
         4'h0,
         ~pins.pos_select_in_n,
         ~pins.dir_select_in_n,
         ~pins.code_data_in_n
      };

      // status word five
      next_st.word_five = {
         6'h00,
         ~core_outs.point_out_n,
         ~core_outs.error_out_n,
         ~core_outs.alarm_code_out_n,
         ~core_outs.position_out_n,
         ~core_outs.manual_latch_out_n,
         ~core_outs.auto_latch_out_n
      };

      // x4 quadrature count, cleared on phase u rising edge
      cur_ab = {pins.enc_a, pins.enc_b};
      next_st.prev_ab = cur_ab;
      next_st.prev_u = pins.enc_u;
      ab_step = (cur_ab[1] ^ st.prev_ab[1]) ^ (cur_ab[0] ^ st.prev_ab[0]);
      ab_fwd = st.prev_ab[1] ^ cur_ab[0];
      u_edge = pins.enc_u & ~st.prev_u;
      if (u_edge) begin
         next_st.u_pulses = '0;
      end else if (ab_step) begin
         if (ab_fwd) begin
            next_st.u_pulses = st.u_pulses + 32'sh00000001;
         end else begin
            next_st.u_pulses = st.u_pulses - 32'sh00000001;
         end
      end

      // command pulse counter, 16-bit wrap
      if (core_num.cmd_step_up & ~core_num.cmd_step_down) begin
         next_st.cmd_count = st.cmd_count + 16'h0001;
      end else if (core_num.cmd_step_down & ~core_num.cmd_step_up) begin
         next_st.cmd_count = st.cmd_count - 16'h0001;
      end

      // position error scaling
      if (st.cfg[CFG_ERR_SCALE_BIT]) begin
         err_scaled = core_num.pos_error / ERR_SCALE_DIV;
      end else begin
         err_scaled = core_num.pos_error;
      end

      // selected item
      case (st.item)
         ITEM_ACT_SPEED: begin
            value = core_num.act_speed;
         end
         ITEM_TGT_SPEED: begin
            value = core_num.tgt_speed;
         end
         ITEM_TORQUE: begin
            value = {{16{core_num.torque_pct[15]}}, core_num.torque_pct};
         end
         ITEM_U_PULSES: begin
            value = st.u_pulses;
         end
         ITEM_ELEC_ANGLE: begin
            value = {16'h0000, core_num.elec_angle};
         end
         ITEM_WORD_ONE: begin
            value = {12'h000, st.word_one};
         end
         ITEM_WORD_TWO: begin
            value = {12'h000, st.word_two};
         end
         ITEM_CMD_SPEED: begin
            value = core_num.cmd_speed;
         end
         ITEM_POS_ERR: begin
            value = err_scaled;
         end
         ITEM_CMD_COUNT: begin
            value = {16'h0000, st.cmd_count};
         end
         ITEM_WORD_THREE: begin
            value = {12'h000, st.word_three};
         end
         ITEM_WORD_FOUR: begin
            value = {12'h000, st.word_four};
         end
         ITEM_WORD_FIVE: begin
            value = {12'h000, st.word_five};
         end
         ITEM_SW_POS: begin
            value = core_num.sw_pos;
         end
         ITEM_SW_SPD: begin
            value = core_num.sw_spd;
         end
         ITEM_CUR_POS: begin
            value = core_num.cur_pos;
         end
         default: begin
            value = '0;
         end
      endcase
      next_st.disp.item = st.item;
      next_st.disp.value = value;

      // register reads, data in the following cycle only
      next_st.rdata = '0;
      if (bus_req.rd) begin
         if (reg_hit(bus_req.addr, REG_ITEM)) begin
            next_st.rdata = {{(DATA_W-ITEM_W){1'h0}}, st.item};
         end else if (reg_hit(bus_req.addr, REG_CFG)) begin
            next_st.rdata = {{(DATA_W-CFG_W){1'h0}}, st.cfg};
         end else if (reg_hit(bus_req.addr, REG_VALUE)) begin
            next_st.rdata = st.disp.value;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
         st.item <= ITEM_RST;
         st.cfg <= CFG_RST;
      end else begin
         st <= next_st;
      end
   end

   assign bus_rdata = st.rdata;
   assign display = st.disp;
endmodule

// >>> verif/dsm_monitor_assertions.sv
// port assertions of the drive status monitor
`timescale 1ns/10ps
module dsm_monitor_assertions
   import dsm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire dsm_pkg::dsm_bus_req_t bus_req,
   input wire logic [dsm_pkg::DATA_W-1:0] bus_rdata,
   input wire dsm_pkg::dsm_outs_t core_outs,
   input wire dsm_pkg::dsm_numeric_t core_num,
   input wire dsm_pkg::dsm_display_t display
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence item_write;
      bus_req.wr && bus_req.addr == REG_ITEM;
   endsequence
   sequence shown(logic [3:0] it);
      display.item == it && !$past(rst);
   endsequence
   sequence count_shown;
      display.item == ITEM_CMD_COUNT ##1 display.item == ITEM_CMD_COUNT;
   endsequence
   property count_follows;
      count_shown |-> display.value[15:0] == 16'($past(display.value[15:0]) + $past(core_num.cmd_step_up, 2)
         - $past(core_num.cmd_step_down, 2));
   endproperty
   a_reset_item: assert property (disable iff (1'b0) rst |=> display.item == ITEM_RST && bus_rdata == 32'h0
      && display.value == 32'h0)
      else $error("reset left item, value or read data set");
   a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_count_step: assert property (count_follows)
      else $error("command count step wrong");
   a_item_write: assert property (item_write |-> ##2 display.item == $past(bus_req.wdata[3:0], 2))
      else $error("written item not shown two cycles on");
   a_value_read: assert property (bus_req.rd && bus_req.addr == REG_VALUE |=> bus_rdata == $past(display.value))
      else $error("value read differs from display");
   a_unmapped_read: assert property (bus_req.rd && bus_req.addr > REG_VALUE |=> bus_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_speed_item: assert property (shown(ITEM_ACT_SPEED) |-> display.value == $past(core_num.act_speed))
      else $error("speed item wrong");
   a_torque_sext: assert property (shown(ITEM_TORQUE) |-> $signed(display.value) == $past(core_num.torque_pct))
      else $error("torque item wrong");
   a_count_range: assert property (display.item == ITEM_CMD_COUNT |-> display.value[31:16] == 16'h0)
      else $error("command count above 16 bits");
   a_word_one_top: assert property (display.item == ITEM_WORD_ONE |-> display.value[31:19] == 13'h0)
      else $error("unused word one bits lit");
   a_word_five_low: assert property (display.item == ITEM_WORD_FIVE
      |-> display.value[0] == !$past(core_outs.auto_latch_out_n, 2))
      else $error("word five position 1 wrong");
endmodule
bind dsm_monitor dsm_monitor_assertions chk (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .core_outs(core_outs), .core_num(core_num), .display(display));

// >>> verif/dsm_core_model.sv
// control core model: fixed quantities and command steps
`timescale 1ns/10ps
module dsm_core_model
   import dsm_pkg::*;
(
   input wire logic [1:0] step,
   output dsm_pkg::dsm_numeric_t num
);
   always_comb begin
      num = '{act_speed: 32'h0000_0bb8, tgt_speed: 32'hffff_fc18, torque_pct: 16'hff9c, elec_angle: 16'h00b4,
         cmd_speed: 32'h0000_0064, pos_error: 32'hffff_cfc7, sw_pos: 32'h0001_e240, sw_spd: 32'h0000_01f4,
         cur_pos: 32'h7fff_fffe, cmd_step_up: step[1], cmd_step_down: step[0]};
   end
endmodule

// >>> verif/test_drive_status_monitor_mux.sv
// self-checking bench of the drive status monitor mux
`timescale 1ns/10ps
module test_drive_status_monitor_mux;
   import dsm_pkg::*;
   logic core_clk;
   logic rst;
   dsm_bus_req_t req;
   logic [DATA_W-1:0] rdata;
   dsm_pins_t pins;
   dsm_flags_t flags;
   dsm_outs_t outs;
   dsm_numeric_t num;
   dsm_display_t disp;
   logic [1:0] step;
   logic [CFG_W-1:0] cfg;
   logic [DATA_W-1:0] got;
   logic [3:0] items[9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h8, 4'hd, 4'he, 4'hf};
   int err_count;
   int n_tests;
   int cycles;
   dsm_core_model core (.step(step), .num(num));
   dsm_monitor uut (.core_clk(core_clk), .rst(rst), .bus_req(req), .bus_rdata(rdata), .pin_in(pins),
      .core_flags(flags), .core_outs(outs), .core_num(num), .display(disp));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic wrap_up;
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] e);
      n_tests++;
      if (got !== e) begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req.wr <= 1'b0;
      if (a == REG_CFG) cfg = d[15:0];
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk);
      req.rd <= 1'b0;
      @(negedge core_clk);
      got = rdata;
   endtask
   task automatic show(input logic [3:0] it);
      wr(REG_ITEM, {28'h0, it});
      repeat (6) @(posedge core_clk);
      rd(REG_VALUE);
   endtask
   task automatic pulse(input logic [1:0] v);
      @(posedge core_clk);
      step <= v;
      @(posedge core_clk);
      step <= 2'b00;
   endtask
   task automatic enc(input logic a, input logic b, input logic u);
      @(posedge core_clk);
      pins.enc_a <= a;
      pins.enc_b <= b;
      pins.enc_u <= u;
      repeat (4) @(posedge core_clk);
   endtask
   function automatic logic [31:0] exp_num(input logic [3:0] it);
      case (it)
         ITEM_ACT_SPEED: return num.act_speed;
         ITEM_TGT_SPEED: return num.tgt_speed;
         ITEM_TORQUE: return 32'(num.torque_pct);
         ITEM_ELEC_ANGLE: return {16'h0, num.elec_angle};
         ITEM_CMD_SPEED: return num.cmd_speed;
         ITEM_POS_ERR: return num.pos_error;
         ITEM_SW_POS: return num.sw_pos;
         ITEM_SW_SPD: return num.sw_spd;
         default: return num.cur_pos;
      endcase
   endfunction
   function automatic logic [31:0] exp_word(input logic [3:0] it);
      case (it)
         ITEM_WORD_ONE: return {13'h0, pins.rev_overtravel_in, pins.fwd_overtravel_in, ~pins.prop_ctrl_in_n,
            ~pins.servo_on_in_n, ~{pins.enc_w, pins.enc_v, pins.enc_u} & {3{flags.enc_incremental}}, ~pins.enc_c,
            ~pins.enc_b, ~pins.enc_a, flags.motor_power, flags.rev_ilim, flags.fwd_ilim, flags.p_ctrl,
            flags.pos_done, flags.rotating, cfg[CFG_REV_BIT], flags.dyn_brake, flags.servo_alarm};
         ITEM_WORD_TWO: return {24'h0, flags.servo_ready, flags.main_power, flags.overload_warn, flags.brake_release,
            flags.ilim, ~pins.line_pg_c, {pins.cmd_pulse_b, pins.cmd_pulse_a} ^ {2{cfg[CFG_PULSE_INV_BIT]}}};
         ITEM_WORD_THREE: return {20'h0, ~{pins.stop_in_n, pins.alarm_clear_in_n, pins.auto_start_in_n,
            pins.latch_in_n, pins.third_speed_in_n, pins.second_speed_in_n, pins.reset_in_n, pins.jog_rev_in_n,
            pins.jog_fwd_in_n, pins.pulse_in_n, pins.manual_in_n, pins.homing_in_n}};
         ITEM_WORD_FOUR: return {16'h0, ~pins.pos_select_in_n, ~pins.dir_select_in_n, ~pins.code_data_in_n};
         default: return {18'h0, ~outs.point_out_n, ~outs.error_out_n, ~outs.alarm_code_out_n,
            ~outs.position_out_n, ~outs.manual_latch_out_n, ~outs.auto_latch_out_n};
      endcase
   endfunction
   task automatic t_reset;
      rd(REG_ITEM);
      chk(32'h0);
      rd(REG_CFG);
      chk(32'h0);
      show(ITEM_CMD_COUNT);
      chk(32'h0);
   endtask
   task automatic t_count;
      pulse(2'b01);
      show(ITEM_CMD_COUNT);
      chk(32'h0000_ffff);
      pulse(2'b10);
      pulse(2'b10);
      pulse(2'b11);
      show(ITEM_CMD_COUNT);
      chk(32'h1);
   endtask
   task automatic t_numeric;
      foreach (items[i]) begin
         show(items[i]);
         chk(exp_num(items[i]));
      end
      wr(REG_CFG, 32'h0000_4000);
      show(ITEM_POS_ERR);
      chk(32'hffff_ff85);
   endtask
   task automatic t_bus;
      wr(REG_VALUE, 32'hffff_ffff);
      wr(4'h7, 32'h5);
      rd(REG_ITEM);
      chk(32'h8);
      rd(4'h9);
      chk(32'h0);
      wr(REG_ITEM, 32'hffff_fff3);
      rd(REG_ITEM);
      chk(32'h3);
   endtask
   task automatic t_words;
      for (int p = 0; p < 2; p++) begin
         @(posedge core_clk);
         pins <= p ? ~41'h1a5_c396_e15a : 41'h1a5_c396_e15a;
         flags <= p ? ~14'h2a5b : 14'h2a5b;
         outs <= p ? ~14'h1c63 : 14'h1c63;
         wr(REG_CFG, p ? 32'h0 : 32'h2001);
         for (int k = 0; k < 5; k++) begin
            show(k < 2 ? 4'(k + 5) : 4'(k + 8));
            chk(exp_word(k < 2 ? 4'(k + 5) : 4'(k + 8)));
         end
      end
   endtask
   task automatic t_pulses;
      enc(1'b0, 1'b0, 1'b0);
      enc(1'b0, 1'b0, 1'b1);
      enc(1'b0, 1'b1, 1'b1);
      enc(1'b1, 1'b1, 1'b1);
      enc(1'b1, 1'b0, 1'b1);
      show(ITEM_U_PULSES);
      chk(32'h3);
      enc(1'b1, 1'b1, 1'b0);
      show(ITEM_U_PULSES);
      chk(32'h2);
      enc(1'b1, 1'b1, 1'b1);
      show(ITEM_U_PULSES);
      chk(32'h0);
   endtask
   initial begin
      rst = 1'b1;
      req = '0;
      pins = '0;
      flags = '0;
      outs = '1;
      step = 2'b00;
      cfg = '0;
      got = '0;
      err_count = 0;
      n_tests = 0;
      cycles = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_count();
      t_numeric();
      t_bus();
      t_words();
      t_pulses();
      wr(REG_CFG, 32'h0000_6001);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      wrap_up();
   end
endmodule
